// *** design/ret_stack_cfg.svh ***
// constants for the return and interrupt stack unit
// assumes inclusion by its bare name from design and bench files
`ifndef RET_STACK_CFG_SVH
`define RET_STACK_CFG_SVH

// program counter and stack geometry
`define RS_PC_W 13
`define RS_STACK_DEPTH 8
`define RS_IRQ_VECTOR 13'h0004
// byte-wide data path
`define RS_DATA_W 8
// global interrupt enable position in the interrupt control register
`define RS_IRQ_EN_BIT 7
// data memory: bank select width, in-bank address width, shared low bytes
`define RS_BANK_W 1
`define RS_BANK_ADDR_W 7
`define RS_COMMON_BYTES 16
// reset values
`define RS_PC_RST 13'h0000
`define RS_BYTE_RST 8'h00
// length of every return in instruction cycles
`define RS_RET_CYCLES 2

`endif

// *** design/ret_stack_pkg.sv ***
// types shared by the return and interrupt stack unit
// assumes the cfg header is compiled alongside
package ret_stack_pkg;

    // sequencing state: exec runs instructions, flush is the second cycle of a branch
    typedef enum logic [0:0] {
        ST_EXEC  = 1'b0,
        ST_FLUSH = 1'b1
    } seq_state_e;

endpackage

// *** design/common_bank_map.sv ***
// resolves a banked data address into a physical data memory address
// assumes a purely combinational use inside the core clock domain
`timescale 1ns/100ps
`include "ret_stack_cfg.svh"

module common_bank_map #(
    parameter int BANK_W = `RS_BANK_W,
    parameter int ADDR_W = `RS_BANK_ADDR_W,
    parameter int COMMON = `RS_COMMON_BYTES
) (
    input wire logic [BANK_W-1:0] bank_sel_i,
    input wire logic [ADDR_W-1:0] bank_addr_i,
    output logic [BANK_W+ADDR_W-1:0] phys_addr_o
);

    // ==========================================================
    // elaboration check
    generate
        if (COMMON < 1 || COMMON > (1 << ADDR_W))
        begin : g_bad_common
            $error("common region does not fit in a bank");
        end
    endgenerate

    // ==========================================================
    // address resolution
    // low locations ignore the bank select, so all banks share them
    always_comb
    begin
        if (int'(bank_addr_i) < COMMON)
        begin
            phys_addr_o = {{BANK_W{1'b0}}, bank_addr_i};
        end
        else
        begin
            phys_addr_o = {bank_sel_i, bank_addr_i};
        end
    end

endmodule

// *** design/ret_stack_unit.sv ***
// return and interrupt stack unit of the core sequencer
// assumes the decoder raises at most what it means to execute this cycle,
// one clock equals one instruction cycle, sys_rst_i is the device reset
// Function
// - interrupt entry saves only return program counter
// - low 16 bytes shared by every bank
// - interrupt return pops top into counter, two cycles
// - interrupt return sets global interrupt enable bit
// - literal return loads 8-bit literal into working
// - literal return pops counter, two cycles total
// - plain return pops top into counter, two cycles
`timescale 1ns/100ps
`include "ret_stack_cfg.svh"

module ret_stack_unit
    import ret_stack_pkg::*;
#(
    parameter int PC_W = `RS_PC_W,
    parameter int DEPTH = `RS_STACK_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic pc_inc_i,
    input wire logic call_i,
    input wire logic [PC_W-1:0] call_target_i,
    input wire logic irq_entry_i,
    input wire logic return_i,
    input wire logic return_with_literal_op_i,
    input wire logic [`RS_DATA_W-1:0] literal_i,
    input wire logic return_from_interrupt_op_i,
    input wire logic w_wr_i,
    input wire logic [`RS_DATA_W-1:0] w_data_i,
    input wire logic status_wr_i,
    input wire logic [`RS_DATA_W-1:0] status_data_i,
    input wire logic intctl_wr_i,
    input wire logic [`RS_DATA_W-1:0] intctl_data_i,
    input wire logic [`RS_BANK_W-1:0] bank_sel_i,
    input wire logic [`RS_BANK_ADDR_W-1:0] bank_addr_i,
    output logic [PC_W-1:0] program_counter_o,
    output logic [`RS_DATA_W-1:0] working_reg_o,
    output logic [`RS_DATA_W-1:0] status_o,
    output logic [`RS_DATA_W-1:0] interrupt_control_reg_o,
    output logic [$clog2(DEPTH)-1:0] stack_ptr_o,
    output logic flush_o,
    output logic [`RS_BANK_W+`RS_BANK_ADDR_W-1:0] data_addr_o
);

    localparam int SP_W = $clog2(DEPTH);

    // ==========================================================
    // elaboration check
    generate
        if (PC_W < 4 || DEPTH < 2 || (1 << SP_W) != DEPTH)
        begin : g_bad_param
            $error("stack depth must be a power of two, counter at least 4 bits");
        end
    endgenerate

    // ==========================================================
    // state
    seq_state_e state_r, state_nxt; // exec or flush cycle
    logic [PC_W-1:0] pc_r, pc_nxt; // program counter
    logic [SP_W-1:0] sp_r, sp_nxt; // next free slot, wraps
    logic [`RS_DATA_W-1:0] w_r, w_nxt; // working register
    logic [`RS_DATA_W-1:0] status_r, status_nxt; // status flags
    logic [`RS_DATA_W-1:0] intctl_r, intctl_nxt; // interrupt control
    logic [PC_W-1:0] stack_mem [DEPTH]; // return address stack
    logic push_en; // write a stack slot this cycle
    logic [PC_W-1:0] push_val; // value written to the stack
    logic [PC_W-1:0] top_val; // stack_top_entry
    logic [SP_W-1:0] top_idx; // index of stack_top_entry
    logic [`RS_BANK_W+`RS_BANK_ADDR_W-1:0] map_addr; // resolved data address
    logic [`RS_BANK_W+`RS_BANK_ADDR_W-1:0] data_addr_r; // registered data address
    logic can_exec; // ops only taken in exec cycle
    logic do_irq, do_ret_int, do_ret_lit, do_ret, do_call, do_any;

    // ==========================================================
    // shared bank mapper
    common_bank_map #(
        .BANK_W(`RS_BANK_W),
        .ADDR_W(`RS_BANK_ADDR_W),
        .COMMON(`RS_COMMON_BYTES)
    ) u_map (
        .bank_sel_i(bank_sel_i),
        .bank_addr_i(bank_addr_i),
        .phys_addr_o(map_addr)
    );

    // ==========================================================
    // operation select, fixed priority
    assign top_idx = sp_r - SP_W'(1);
    assign top_val = stack_mem[top_idx];
    assign can_exec = (state_r == ST_EXEC);
    assign do_irq = can_exec && irq_entry_i;
    assign do_ret_int = can_exec && !irq_entry_i && return_from_interrupt_op_i;
    assign do_ret_lit = can_exec && !irq_entry_i && !return_from_interrupt_op_i
        && return_with_literal_op_i;
    assign do_ret = can_exec && !irq_entry_i && !return_from_interrupt_op_i
        && !return_with_literal_op_i && return_i;
    assign do_call = can_exec && !irq_entry_i && !return_from_interrupt_op_i
        && !return_with_literal_op_i && !return_i && call_i;
    assign do_any = do_irq || do_ret_int || do_ret_lit || do_ret || do_call;

    // ==========================================================
    // next values
    always_comb
    begin
        state_nxt = ST_EXEC;
        pc_nxt = pc_r;
        sp_nxt = sp_r;
        w_nxt = w_r;
        status_nxt = status_r;
        intctl_nxt = intctl_r;
        push_en = 1'b0;
        push_val = pc_r;
        // software writes, overridden below by hardware events
        if (w_wr_i)
        begin
            w_nxt = w_data_i;
        end
        if (status_wr_i)
        begin
            status_nxt = status_data_i;
        end
        if (intctl_wr_i)
        begin
            intctl_nxt = intctl_data_i;
        end
        if (do_irq)
        begin
            push_en = 1'b1;
            push_val = pc_r;
            sp_nxt = sp_r + SP_W'(1);
            pc_nxt = `RS_IRQ_VECTOR;
            intctl_nxt[`RS_IRQ_EN_BIT] = 1'b0;
            state_nxt = ST_FLUSH;
        end
        else if (do_ret_int)
        begin
            pc_nxt = top_val;
            sp_nxt = top_idx;
            intctl_nxt[`RS_IRQ_EN_BIT] = 1'b1;
            state_nxt = ST_FLUSH;
        end
        else if (do_ret_lit)
        begin
            w_nxt = literal_i;
            pc_nxt = top_val;
            sp_nxt = top_idx;
            state_nxt = ST_FLUSH;
        end
        else if (do_ret)
        begin
            pc_nxt = top_val;
            sp_nxt = top_idx;
            state_nxt = ST_FLUSH;
        end
        else if (do_call)
        begin
            // subroutine call pushes the next address
            push_en = 1'b1;
            push_val = pc_r + PC_W'(1);
            sp_nxt = sp_r + SP_W'(1);
            pc_nxt = call_target_i;
            state_nxt = ST_FLUSH;
        end
        else if (can_exec && pc_inc_i)
        begin
            // sequential fetch
            pc_nxt = pc_r + PC_W'(1);
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_r <= ST_EXEC;
            pc_r <= `RS_PC_RST;
            sp_r <= '0;
            w_r <= `RS_BYTE_RST;
            status_r <= `RS_BYTE_RST;
            intctl_r <= `RS_BYTE_RST;
            data_addr_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            sp_r <= sp_nxt;
            w_r <= w_nxt;
            status_r <= status_nxt;
            intctl_r <= intctl_nxt;
            data_addr_r <= map_addr;
        end
    end

    // stack storage, no reset needed for contents
    always_ff @(posedge clk_sys_i)
    begin
        if (push_en)
        begin
            stack_mem[sp_r] <= push_val;
        end
    end

    // ==========================================================
    // outputs
    assign program_counter_o = pc_r;
    assign working_reg_o = w_r;
    assign status_o = status_r;
    assign interrupt_control_reg_o = intctl_r;
    assign stack_ptr_o = sp_r;
    assign flush_o = (state_r == ST_FLUSH);
    assign data_addr_o = data_addr_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    chk_irq_pc_only: assert property (
        do_irq && !w_wr_i && !status_wr_i |=> w_r == $past(w_r)
            && status_r == $past(status_r) && stack_mem[$past(sp_r)] == $past(pc_r))
        else $error("interrupt entry saved more than the counter");
    chk_common_map: assert property (
        int'(bank_addr_i) < `RS_COMMON_BYTES |=> data_addr_r[`RS_BANK_ADDR_W +: `RS_BANK_W] == '0
            && data_addr_r[`RS_BANK_ADDR_W-1:0] == $past(bank_addr_i))
        else $error("low byte not shared across banks");
    chk_intret_pop: assert property (
        do_ret_int |=> pc_r == $past(top_val) && sp_r == $past(top_idx) && flush_o
            ##1 !flush_o)
        else $error("interrupt return did not pop in two cycles");
    chk_intret_enable: assert property (
        do_ret_int |=> intctl_r[`RS_IRQ_EN_BIT])
        else $error("interrupt return left interrupts disabled");
    chk_litret_literal: assert property (
        do_ret_lit |=> w_r == $past(literal_i))
        else $error("literal return did not load working");
    chk_litret_pop: assert property (
        do_ret_lit |=> pc_r == $past(top_val) && flush_o ##1 state_r == ST_EXEC)
        else $error("literal return did not pop in two cycles");
    chk_ret_pop: assert property (
        do_ret |=> pc_r == $past(top_val) && sp_r == $past(sp_r) - SP_W'(1)
            ##1 $stable(pc_r) && can_exec)
        else $error("plain return did not pop in two cycles");
    chk_ret_status: assert property (
        (do_ret || do_ret_lit || do_ret_int) && !status_wr_i |=> $stable(status_r))
        else $error("return modified status flags");

    // sequences the bench really runs: ops are taken three or more cycles apart
    cov_int_return: cover property (do_ret_int ##[2:8] do_ret);
    cov_lit_return: cover property (do_call ##[2:8] do_ret_lit);
    cov_irq: cover property (do_irq ##[2:8] do_ret_int);
    cov_common: cover property (int'(bank_addr_i) < `RS_COMMON_BYTES && bank_sel_i != '0);

endmodule

// *** tb/tb.sv ***
// self-checking bench for the return and interrupt stack unit
// assumes the cfg header and package are compiled first
`timescale 1ns/100ps
`include "ret_stack_cfg.svh"
module tb
    import ret_stack_pkg::*;
;
// ==========================================
// signals and reference model
typedef struct packed {logic [12:0] pc; logic [7:0] w; logic [7:0] st; logic [7:0] ic;
    logic [2:0] sp;} note_s;
logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, pc_inc_i = 1'b0, call_i = 1'b0, irq_entry_i = 1'b0;
logic return_i = 1'b0, ret_lit = 1'b0, ret_int = 1'b0, w_wr_i = 1'b0, status_wr_i = 1'b0;
logic intctl_wr_i = 1'b0;
logic [12:0] call_target_i = 13'h0000;
logic [7:0] literal_i = 8'h00, w_data_i = 8'h00, status_data_i = 8'h00, intctl_data_i = 8'h00;
logic [0:0] bank_sel_i = 1'b0;
logic [6:0] bank_addr_i = 7'h00;
logic [12:0] program_counter_o;
logic [7:0] working_reg_o, status_o, interrupt_control_reg_o, data_addr_o;
logic [2:0] stack_ptr_o;
logic flush_o;
logic [12:0] m_pc = 13'h0000; // model state
logic [12:0] m_stk [8];
logic [7:0] m_w = 8'h00, m_st = 8'h00, m_ic = 8'h00;
logic [2:0] m_sp = 3'h0;
note_s opq[$]; // expected op results
logic [15:0] aq[$]; // expected resolved addresses
int mismatches = 0, tests_run = 0, cyc = 0;
ret_stack_unit u_ret_stack_unit (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .pc_inc_i(pc_inc_i), .call_i(call_i), .call_target_i(call_target_i),
    .irq_entry_i(irq_entry_i), .return_i(return_i), .return_with_literal_op_i(ret_lit),
    .literal_i(literal_i), .return_from_interrupt_op_i(ret_int), .w_wr_i(w_wr_i),
    .w_data_i(w_data_i), .status_wr_i(status_wr_i), .status_data_i(status_data_i),
    .intctl_wr_i(intctl_wr_i), .intctl_data_i(intctl_data_i), .bank_sel_i(bank_sel_i),
    .bank_addr_i(bank_addr_i), .program_counter_o(program_counter_o),
    .working_reg_o(working_reg_o), .status_o(status_o),
    .interrupt_control_reg_o(interrupt_control_reg_o), .stack_ptr_o(stack_ptr_o),
    .flush_o(flush_o), .data_addr_o(data_addr_o));
// ==========================================
// clock, timeout and helpers
initial
begin
    forever #20 clk_sys_i = ~clk_sys_i;
end
// cut a hang short
always @(posedge clk_sys_i)
begin
    cyc++;
    if (cyc == 3000)
    begin
        mismatches++;
        finish_test();
    end
end
task automatic cmp_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
        mismatches++;
        $display("BAD %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic cmp_note(input note_s n);
    cmp_val("pc", 16'(n.pc), 16'(program_counter_o));
    cmp_val("w", 16'(n.w), 16'(working_reg_o));
    cmp_val("status", 16'(n.st), 16'(status_o));
    cmp_val("intctl", 16'(n.ic), 16'(interrupt_control_reg_o));
    cmp_val("sp", 16'(n.sp), 16'(stack_ptr_o));
endtask
task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
// one branch op: 0 call, 1 irq, 2 return, 3 literal return, 4 interrupt return
task automatic do_op(input int k, input logic [12:0] tgt, input logic [7:0] lit);
    @(posedge clk_sys_i);
    call_i <= (k == 0);
    irq_entry_i <= (k == 1);
    return_i <= (k == 2);
    ret_lit <= (k == 3);
    ret_int <= (k == 4);
    call_target_i <= tgt;
    literal_i <= lit;
    if (k < 2)
    begin
        m_stk[m_sp] = (k == 0) ? m_pc + 13'h0001 : m_pc;
        m_sp++;
        m_pc = (k == 0) ? tgt : 13'h0004;
    end
    else
    begin
        m_sp--;
        m_pc = m_stk[m_sp];
    end
    if (k == 1) m_ic[7] = 1'b0;
    if (k == 3) m_w = lit;
    if (k == 4) m_ic[7] = 1'b1;
    opq.push_back('{m_pc, m_w, m_st, m_ic, m_sp});
    @(posedge clk_sys_i);
    {call_i, irq_entry_i, return_i, ret_lit, ret_int} <= 5'h00;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    cmp_val("flush_end", 16'h0000, 16'(flush_o));
endtask
// software writes of working, status and interrupt control
task automatic sw(input logic [7:0] w, input logic [7:0] st, input logic [7:0] ic);
    @(posedge clk_sys_i);
    {w_wr_i, status_wr_i, intctl_wr_i} <= 3'h7;
    w_data_i <= w;
    status_data_i <= st;
    intctl_data_i <= ic;
    {m_w, m_st, m_ic} = {w, st, ic};
    @(posedge clk_sys_i);
    {w_wr_i, status_wr_i, intctl_wr_i} <= 3'h0;
endtask
// ==========================================
// watcher: op results show while flush is high
always @(negedge clk_sys_i)
begin
    if (!sys_rst_i && flush_o === 1'b1)
    begin
        if (opq.size() == 0)
            cmp_val("unexpected_flush", 16'h0000, 16'h0001);
        else
            cmp_note(opq.pop_front());
    end
    if (aq.size() > 0)
        cmp_val("data_addr", aq.pop_front(), 16'(data_addr_o));
end
// ==========================================
// main sequence
initial
begin
    logic [6:0] a;
    logic b;
    void'($urandom(15));
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_sys_i);
    cmp_note('{13'h0000, 8'h00, 8'h00, 8'h00, 3'h0});
    $display("test reset done");
    // shared low bytes across banks, edges 15 and 16 included
    for (int i = 0; i < 14; i++)
    begin
        a = (i == 0) ? 7'h0f : (i == 1) ? 7'h10 : 7'($urandom);
        b = 1'($urandom) | (i < 2);
        @(posedge clk_sys_i);
        bank_sel_i <= b;
        bank_addr_i <= a;
        @(posedge clk_sys_i);
        aq.push_back((a < 7'h10) ? {8'h00, 1'b0, a} : {8'h00, b, a});
    end
    $display("test bank map done");
    // nested calls unwound by literal and plain returns
    sw(8'($urandom), 8'($urandom), 8'h80);
    @(posedge clk_sys_i);
    pc_inc_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    pc_inc_i <= 1'b0;
    m_pc = m_pc + 13'h0003;
    for (int i = 0; i < 4; i++)
        do_op(0, 13'($urandom), 8'h00);
    do_op(3, 13'h0000, 8'hff);
    do_op(3, 13'h0000, 8'h00);
    do_op(3, 13'h0000, 8'($urandom));
    do_op(2, 13'h0000, 8'h00);
    $display("test returns done");
    // interrupt entry, handler writes, interrupt return
    do_op(0, 13'h0123, 8'h00);
    do_op(1, 13'h0000, 8'h00);
    sw(8'($urandom), 8'($urandom), 8'h7f);
    do_op(4, 13'h0000, 8'h00);
    do_op(2, 13'h0000, 8'h00);
    $display("test interrupt return done");
    repeat (3) @(posedge clk_sys_i);
    cmp_val("pending", 16'h0000, 16'(opq.size() + aq.size()));
    finish_test();
end
endmodule
